// ==== rtl/dws_top.sv ====
// Dual watchdog supervisor: free-running and window watchdogs with APB slave
// Overview of operation
// - 18-bit up counter runs while enabled
// - Time-out selectable 2^4 to 2^18 ticks
// - Hold system reset for 63 ticks
// - Reset delay 3, 18, 130, 1026 ticks
// - Reset flag status bit1, delay ctl[9:8]
// - Boot field forces free-running watchdog on
// - Wake-up only from LOW_SPEED_INTERNAL_RC or LOW_SPEED_CRYSTAL
// - Free-running counter keeps counting in power-down
// - Window: 6-bit down counter, 6-bit compare
// - 4-bit select picks up-to-11-bit prescaler
// - Window reset when counter reaches zero
// - Reload above compare value causes reset
// - Window flag set resets system immediately
// - Window counter frozen in idle/power-down
// - Window watchdog never wakes the chip
// - Window enabled only by its control bit
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dws_top #(
   parameter int TICK_DIV = dws_pkg::TICK_DIV
) (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [2:0]  boot_force_enable_field,
   input  wire logic [1:0]  clk_source_select,
   input  wire logic        idle_mode,
   input  wire logic        power_down_mode,
   output logic             system_reset,
   output logic             wake_up
);
   logic [15:0] div_cnt;
   logic        tick;
   logic        pd_s1, pd_s2, idle_s1, idle_s2;
   logic [2:0]  boot_s1, boot_s2;
   logic [1:0]  src_s1, src_s2;
   logic        boot_force;
   logic [1:0]  boot_wait;
   logic [31:0] freerun_control_reg;
   logic [31:0] window_control_reg;
   logic [dws_pkg::FR_CNT_W-1:0] fr_cnt;
   logic        fr_tof, wd_reset_flag, fr_wkf;
   logic        fr_dly_run;
   logic [10:0] fr_dly_cnt;
   logic [6:0]  hold_cnt;
   logic [dws_pkg::WIN_CNT_W-1:0] window_down_counter;
   logic [dws_pkg::PRE_W-1:0]     pre_cnt;
   logic        window_reset_flag;
   logic        fr_en, win_en, win_run, pre_hit, fr_to_hit;
   logic        wr, key_wr, key_early, fr_clr_cnt;
   logic [4:0]  fr_to_exp;
   logic [1:0]  reset_delay_select;
   logic [3:0]  tosel, prescale_period_select;
   logic [5:0]  window_compare_value;
   logic [10:0] dly_limit;
   logic [10:0] pre_limit;

   function automatic logic [10:0] delay_ticks(input logic [1:0] sel);
      unique case (sel)
         2'h0: delay_ticks = 11'h402;
         2'h1: delay_ticks = 11'h082;
         2'h2: delay_ticks = 11'h012;
         2'h3: delay_ticks = 11'h003;
      endcase
   endfunction

   // Double-rank every level from outside the clock domain
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pd_s1   <= 1'b0;
         pd_s2   <= 1'b0;
         idle_s1 <= 1'b0;
         idle_s2 <= 1'b0;
         boot_s1 <= 3'h7;
         boot_s2 <= 3'h7;
         src_s1  <= 2'h0;
         src_s2  <= 2'h0;
      end else begin
         pd_s1   <= power_down_mode;
         pd_s2   <= pd_s1;
         idle_s1 <= idle_mode;
         idle_s2 <= idle_s1;
         boot_s1 <= boot_force_enable_field;
         boot_s2 <= boot_s1;
         src_s1  <= clk_source_select;
         src_s2  <= src_s1;
      end
   end

   // Boot field caught once after release, not at reset itself
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         boot_force <= 1'b0;
         boot_wait  <= 2'h0;
      end else if (boot_wait != 2'h3) begin
         boot_wait  <= boot_wait + 2'h1;
         // Second rank holds the pin value only from the second edge on
         if (boot_wait == 2'h2)
            boot_force <= (boot_s2 == dws_pkg::BOOT_FORCE_CODE);
      end
   end

   // Watchdog tick enable from the core clock
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         div_cnt <= 16'h0000;
         tick    <= 1'b0;
      end else if (div_cnt == 16'(TICK_DIV - 1)) begin
         div_cnt <= 16'h0000;
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
         tick    <= 1'b0;
      end
   end

   assign wr = psel && penable && pwrite;
   assign key_wr = wr && paddr == dws_pkg::ADDR_WIN_KEY && pwdata == dws_pkg::RELOAD_KEY;
   assign key_early = key_wr && win_en && (window_down_counter > window_compare_value);
   assign fr_clr_cnt = wr && paddr == dws_pkg::ADDR_FR_STS && pwdata[dws_pkg::FR_TOF_BIT + 3];
   assign fr_en  = freerun_control_reg[dws_pkg::FR_EN_BIT] || boot_force;
   assign win_en = window_control_reg[dws_pkg::WIN_EN_BIT];
   assign reset_delay_select = freerun_control_reg[dws_pkg::FR_DLY_LO +: 2];
   assign tosel = freerun_control_reg[dws_pkg::FR_TOSEL_LO +: 4];
   assign prescale_period_select = window_control_reg[dws_pkg::WIN_PSEL_LO +: 4];
   assign window_compare_value = window_control_reg[dws_pkg::WIN_CMP_LO +: 6];
   assign dly_limit = delay_ticks(reset_delay_select);
   // Time-out at 2^(4+2*sel), sel 0..7 gives 2^4..2^18
   // Exponent kept at five bits, since 4 + 14 would wrap in four
   assign fr_to_exp = {1'b0, dws_pkg::TOSEL_MIN_EXP} + {1'b0, tosel[2:0], 1'b0};
   assign fr_to_hit = fr_cnt == 18'((18'h1 << fr_to_exp) - 18'h1);
   assign pre_limit = 11'((12'h1 << prescale_period_select[3:0]) - 12'h1);
   assign pre_hit = (prescale_period_select > 4'hB) ? (pre_cnt == 11'h7FF) : (pre_cnt == pre_limit);
   // Window counter stalls in low-power states
   assign win_run = win_en && tick && !idle_s2 && !pd_s2;

   // Control registers; window enable is sticky once set
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         freerun_control_reg <= 32'h00000000;
         window_control_reg  <= 32'h003F0000;
      end else if (wr) begin
         if (paddr == dws_pkg::ADDR_FR_CTL)
            freerun_control_reg <= pwdata & 32'h000003F7;
         if (paddr == dws_pkg::ADDR_WIN_CTL && !win_en)
            window_control_reg <= pwdata & 32'h003F0F01;
      end
   end

   // Free-running up counter keeps going in power-down
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         fr_cnt <= '0;
      end else if (!fr_en || fr_clr_cnt) begin
         fr_cnt <= '0;
      end else if (tick) begin
         fr_cnt <= fr_to_hit ? '0 : fr_cnt + 18'h1;
      end
   end

   // Time-out, delay and reset flag; set wins over a software clear
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         fr_tof        <= 1'b0;
         wd_reset_flag <= 1'b0;
         fr_wkf        <= 1'b0;
         fr_dly_run    <= 1'b0;
         fr_dly_cnt    <= 11'h000;
      end else begin
         if (fr_en && tick && fr_to_hit) begin
            fr_tof <= 1'b1;
            if (freerun_control_reg[dws_pkg::FR_WAKE_EN] && pd_s2 &&
                (src_s2 == dws_pkg::SRC_LOW_SPEED_INTERNAL_RC || src_s2 == dws_pkg::SRC_LXT))
               fr_wkf <= 1'b1;
            if (freerun_control_reg[dws_pkg::FR_RSTEN_BIT] || boot_force) begin
               fr_dly_run <= 1'b1;
               fr_dly_cnt <= 11'h000;
            end
         end else if (wr && paddr == dws_pkg::ADDR_FR_STS) begin
            if (pwdata[dws_pkg::FR_TOF_BIT]) fr_tof <= 1'b0;
            if (pwdata[dws_pkg::FR_WKF_BIT]) fr_wkf <= 1'b0;
            if (pwdata[dws_pkg::FR_WD_RESET_FLAG_BIT]) wd_reset_flag <= 1'b0;
         end
         if (fr_dly_run && fr_clr_cnt) begin
            fr_dly_run <= 1'b0;
         end else if (fr_dly_run && tick) begin
            // A delay shortened mid-count still ends instead of wrapping
            if (fr_dly_cnt >= dly_limit - 11'h001) begin
               fr_dly_run <= 1'b0;
               wd_reset_flag <= 1'b1;
            end else begin
               fr_dly_cnt <= fr_dly_cnt + 11'h001;
            end
         end
      end
   end

   // Window prescaler and down counter
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pre_cnt <= '0;
         window_down_counter <= 6'h3F;
      end else if (key_wr && win_en && !key_early) begin
         pre_cnt <= '0;
         window_down_counter <= 6'h3F;
      end else if (win_run) begin
         if (pre_hit) begin
            pre_cnt <= '0;
            if (window_down_counter != 6'h00)
               window_down_counter <= window_down_counter - 6'h01;
         end else begin
            pre_cnt <= pre_cnt + 11'h001;
         end
      end
   end

   // Window flag: zero count or early reload; clear loses to a set
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         window_reset_flag <= 1'b0;
      end else if ((win_en && window_down_counter == 6'h00) || key_early) begin
         window_reset_flag <= 1'b1;
      end else if (wr && paddr == dws_pkg::ADDR_WIN_STS && pwdata[dws_pkg::WIN_WD_RESET_FLAG_BIT]) begin
         window_reset_flag <= 1'b0;
      end
   end

   // System reset hold counter, 63 ticks
   // Flags are levels, so the hold rearms until software clears them
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         hold_cnt <= 7'h00;
         system_reset <= 1'b0;
      end else if (window_reset_flag && !system_reset) begin
         system_reset <= 1'b1;
         hold_cnt <= 7'h00;
      end else if (wd_reset_flag && !system_reset && tick) begin
         system_reset <= 1'b1;
         hold_cnt <= 7'h00;
      end else if (system_reset && tick) begin
         if (hold_cnt == dws_pkg::HOLD_TICKS - 7'h01) begin
            system_reset <= 1'b0;
         end else begin
            hold_cnt <= hold_cnt + 7'h01;
         end
      end
   end

   // Wake only from the free-running watchdog
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) wake_up <= 1'b0;
      else wake_up <= fr_wkf;
   end

   // APB slave, zero wait states
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (psel && !penable) begin
            unique case (paddr)
               dws_pkg::ADDR_FR_CTL:  prdata <= freerun_control_reg | {31'h0, boot_force};
               dws_pkg::ADDR_FR_STS:  prdata <= {29'h0, fr_wkf, wd_reset_flag, fr_tof};
               dws_pkg::ADDR_WIN_KEY: prdata <= 32'h00000000;
               dws_pkg::ADDR_WIN_CTL: prdata <= window_control_reg;
               dws_pkg::ADDR_WIN_STS: prdata <= {18'h0, window_down_counter, 7'h0, window_reset_flag};
               default: pslverr <= !pwrite;
            endcase
         end
      end
   end

   // Checks beside the logic they guard
   a_hold_end: assert property (@(posedge core_clk) disable iff (reset)
      system_reset && tick && hold_cnt == dws_pkg::HOLD_TICKS - 7'h01 |=> !system_reset)
      else $error("system reset not released after hold");
   a_hold_stays: assert property (@(posedge core_clk) disable iff (reset)
      system_reset && hold_cnt != dws_pkg::HOLD_TICKS - 7'h01 |=> system_reset)
      else $error("system reset released early");
   a_delay_flag: assert property (@(posedge core_clk) disable iff (reset)
      fr_dly_run && tick && !fr_clr_cnt && fr_dly_cnt == dly_limit - 11'h001 |=> wd_reset_flag)
      else $error("reset flag missing after delay");
   a_fr_wrap: assert property (@(posedge core_clk) disable iff (reset)
      fr_en && tick && fr_to_hit && !fr_clr_cnt |=> fr_cnt == 18'h00000 && fr_tof)
      else $error("time-out not taken");
   a_fr_pd_runs: assert property (@(posedge core_clk) disable iff (reset)
      pd_s2 && fr_en && tick && !fr_to_hit && !fr_clr_cnt |=> fr_cnt == $past(fr_cnt) + 18'h1)
      else $error("free counter stalled in power-down");
   a_win_no_wake: assert property (@(posedge core_clk) disable iff (reset)
      wake_up |-> $past(fr_wkf))
      else $error("wake without free watchdog flag");
   a_key_off: assert property (@(posedge core_clk) disable iff (reset)
      key_wr && !win_en |=> $stable(window_down_counter))
      else $error("disabled window counter reloaded");
   a_pre_step: assert property (@(posedge core_clk) disable iff (reset)
      win_run && !pre_hit && !key_wr |=> pre_cnt == $past(pre_cnt) + 11'h001)
      else $error("prescaler did not advance");
   a_win_immediate: assert property (@(posedge core_clk) disable iff (reset)
      window_reset_flag && !system_reset |=> system_reset)
      else $error("window flag did not reset system");
   a_early_key: assert property (@(posedge core_clk) disable iff (reset)
      key_early |=> window_reset_flag)
      else $error("early reload not flagged");
   a_zero_reset: assert property (@(posedge core_clk) disable iff (reset)
      win_en && window_down_counter == 6'h00 |=> window_reset_flag)
      else $error("zero count not flagged");
   a_reload_max: assert property (@(posedge core_clk) disable iff (reset)
      key_wr && win_en && !key_early |=> window_down_counter == 6'h3F)
      else $error("reload not to all ones");
   a_win_freeze: assert property (@(posedge core_clk) disable iff (reset)
      (idle_s2 || pd_s2) && !key_wr |=> $stable(window_down_counter))
      else $error("window counter moved in low power");
   a_win_only_bit: assert property (@(posedge core_clk) disable iff (reset)
      !win_en |=> !window_reset_flag || $past(window_reset_flag))
      else $error("window acted while disabled");
   a_fr_counts: assert property (@(posedge core_clk) disable iff (reset)
      fr_en && tick && !fr_to_hit && !fr_clr_cnt |=> fr_cnt == $past(fr_cnt) + 18'h1)
      else $error("free counter did not advance");
   a_no_wake_src: assert property (@(posedge core_clk) disable iff (reset)
      $rose(fr_wkf) |-> src_s2 == dws_pkg::SRC_LOW_SPEED_INTERNAL_RC || src_s2 == dws_pkg::SRC_LXT)
      else $error("wake from wrong source");
   c_win_zero: cover property (@(posedge core_clk) disable iff (reset) $rose(window_reset_flag));
   c_fr_reset: cover property (@(posedge core_clk) disable iff (reset) $rose(wd_reset_flag));
   c_reload: cover property (@(posedge core_clk) disable iff (reset) key_wr && !key_early);
   c_wake: cover property (@(posedge core_clk) disable iff (reset) $rose(wake_up));
   c_freeze: cover property (@(posedge core_clk) disable iff (reset) win_en && (idle_s2 || pd_s2));
endmodule
`default_nettype wire

// ==== rtl/dws_pkg.sv ====
// Constants for the dual watchdog supervisor
package dws_pkg;
   localparam logic [11:0] ADDR_FR_CTL   = 12'h000;
   localparam logic [11:0] ADDR_FR_STS   = 12'h004;
   localparam logic [11:0] ADDR_WIN_KEY  = 12'h008;
   localparam logic [11:0] ADDR_WIN_CTL  = 12'h00C;
   localparam logic [11:0] ADDR_WIN_STS  = 12'h010;
   localparam logic [31:0] RELOAD_KEY    = 32'h00005AA5;
   localparam int FR_CNT_W      = 18;
   localparam int WIN_CNT_W     = 6;
   localparam int PRE_W         = 11;
   localparam int FR_EN_BIT     = 0;
   localparam int FR_WAKE_EN    = 1;
   localparam int FR_RSTEN_BIT  = 2;
   localparam int FR_TOSEL_LO   = 4;
   localparam int FR_DLY_LO     = 8;
   localparam int FR_TOF_BIT    = 0;
   localparam int FR_WD_RESET_FLAG_BIT   = 1;
   localparam int FR_WKF_BIT    = 2;
   localparam int WIN_EN_BIT    = 0;
   localparam int WIN_PSEL_LO   = 8;
   localparam int WIN_CMP_LO    = 16;
   localparam int WIN_WD_RESET_FLAG_BIT  = 0;
   localparam int WIN_CNT_LO    = 8;
   localparam logic [2:0] BOOT_FORCE_CODE = 3'h0;
   localparam logic [1:0] SRC_LOW_SPEED_INTERNAL_RC = 2'h0;
   localparam logic [1:0] SRC_LXT  = 2'h1;
   localparam logic [6:0] HOLD_TICKS = 7'h3F;
   localparam logic [3:0] TOSEL_MIN_EXP = 4'h4;
   localparam logic [3:0] TOSEL_MAX = 4'h7;
   localparam int TICK_HZ = 10000;
   localparam int CLK_HZ  = 100000000;
   localparam int TICK_DIV = CLK_HZ / TICK_HZ;
endpackage

// ==== tb/dual_watchdog_supervisor_tb_top.sv ====
// Self-checking bench for the dual watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module dual_watchdog_supervisor_tb_top;
   localparam int DIV = 4;
   logic        core_clk;
   logic        reset;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  boot_force_enable_field;
   logic [1:0]  clk_source_select;
   logic        idle_mode;
   logic        power_down_mode;
   logic        system_reset;
   logic        wake_up;
   logic [31:0] rdat;
   logic [31:0] c1;
   logic        rerr;
   int          err_count;
   int          checks_done;
   int          n;
   int          tsel[4] = '{0, 1, 0, 0};
   int          dsel[4] = '{3, 2, 1, 0};
   int          tk[4]   = '{19, 82, 146, 1042};
   logic [1:0]  src[3]  = '{2'h2, 2'h0, 2'h1};

   dws_top #(.TICK_DIV(DIV)) u_dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .boot_force_enable_field(boot_force_enable_field), .clk_source_select(clk_source_select),
      .idle_mode(idle_mode), .power_down_mode(power_down_mode), .system_reset(system_reset), .wake_up(wake_up));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rng(input int v, input int lo, input int hi);
      chk({31'h0, (v >= lo && v <= hi)}, 32'h1);
   endtask

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50)
         chk(32'h0, 32'h1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_rst(input logic lvl, input int mx);
      n = 0;
      while (system_reset !== lvl && n < mx) begin
         @(posedge core_clk);
         n++;
      end
   endtask

   task automatic do_reset();
      reset <= 1'b1;
      repeat (4) @(posedge core_clk);
      reset <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic give_verdict();
      $display("Checks %0d, errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #300us;
      err_count++;
      give_verdict();
   end

   initial begin
      reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      boot_force_enable_field = 3'h7; clk_source_select = 2'h2; idle_mode = 1'b0; power_down_mode = 1'b0;
      err_count = 0;
      checks_done = 0;
      do_reset();
      apb(1'b0, dws_pkg::ADDR_WIN_CTL, 32'h0);
      chk(rdat, 32'h003F0000);
      apb(1'b0, 12'h020, 32'h0);
      chk({rerr, rdat[30:0]}, 32'h80000000);
      // Time-out select and every reset delay
      for (int i = 0; i < 4; i++) begin
         do_reset();
         apb(1'b1, dws_pkg::ADDR_FR_CTL, {22'h0, 2'(dsel[i]), 1'b0, 3'(tsel[i]), 4'h5});
         wait_rst(1'b1, 5000);
         rng(n, tk[i] * DIV - 8, tk[i] * DIV + 8);
         wait_rst(1'b0, 400);
         rng(n, 63 * DIV - 6, 63 * DIV + 6);
         apb(1'b0, dws_pkg::ADDR_FR_STS, 32'h0);
         chk(rdat & 32'h3, 32'h3);
      end
      // Wake only from the two low-speed sources, counting in power-down
      for (int i = 0; i < 3; i++) begin
         do_reset();
         clk_source_select <= src[i];
         power_down_mode <= 1'b1;
         apb(1'b1, dws_pkg::ADDR_FR_CTL, 32'h3);
         repeat (16 * DIV + 20) @(posedge core_clk);
         chk({31'h0, wake_up}, {31'h0, (i != 0)});
         power_down_mode <= 1'b0;
      end
      // Window underflow
      do_reset();
      apb(1'b1, dws_pkg::ADDR_WIN_CTL, 32'h003F0001);
      wait_rst(1'b1, 400);
      rng(n, 63 * DIV, 63 * DIV + 8);
      apb(1'b0, dws_pkg::ADDR_WIN_STS, 32'h0);
      chk(rdat & 32'h1, 32'h1);
      // Early reload key above compare value
      do_reset();
      apb(1'b1, dws_pkg::ADDR_WIN_CTL, 32'h00100B01);
      apb(1'b1, dws_pkg::ADDR_WIN_KEY, dws_pkg::RELOAD_KEY);
      wait_rst(1'b1, 3);
      chk({31'h0, system_reset}, 32'h1);
      // In-window reload, then freeze in idle and power-down with no wake
      do_reset();
      apb(1'b1, dws_pkg::ADDR_WIN_CTL, 32'h003F0401);
      repeat (200) @(posedge core_clk);
      apb(1'b1, dws_pkg::ADDR_WIN_KEY, dws_pkg::RELOAD_KEY);
      apb(1'b0, dws_pkg::ADDR_WIN_STS, 32'h0);
      rng(int'(rdat[13:8]), 62, 63);
      idle_mode <= 1'b1;
      power_down_mode <= 1'b1;
      repeat (6) @(posedge core_clk);
      apb(1'b0, dws_pkg::ADDR_WIN_STS, 32'h0);
      c1 = rdat;
      repeat (100) @(posedge core_clk);
      apb(1'b0, dws_pkg::ADDR_WIN_STS, 32'h0);
      chk(rdat, c1);
      chk({31'h0, wake_up}, 32'h0);
      idle_mode <= 1'b0;
      power_down_mode <= 1'b0;
      // Boot field forces only the free-running watchdog
      boot_force_enable_field <= 3'h0;
      do_reset();
      apb(1'b0, dws_pkg::ADDR_WIN_STS, 32'h0);
      c1 = rdat;
      repeat (100) @(posedge core_clk);
      apb(1'b0, dws_pkg::ADDR_WIN_STS, 32'h0);
      chk(rdat, c1);
      wait_rst(1'b1, 6000);
      chk({31'h0, system_reset}, 32'h1);
      give_verdict();
   end
endmodule
`default_nettype wire
